//--- src/flash_iap_pkg.sv
package flash_iap_pkg;
	localparam logic [7:0]  KEY_SFR_ADDR   = 8'h97;
	localparam logic [7:0]  CODE_SFR_ADDR  = 8'hC9;
	localparam logic [7:0]  KEY_UNLOCK     = 8'h65;
	localparam logic [7:0]  CODE_PROG_LO   = 8'h4A;
	localparam logic [7:0]  CODE_PROG_HI   = 8'h4C;
	localparam logic [7:0]  CODE_ERASE_LO  = 8'hBA;
	localparam logic [7:0]  CODE_ERASE_HI  = 8'hBC;
	localparam logic [7:0]  CODE_OFF       = 8'h00;
	localparam logic [15:0] CFG_ADDR       = 16'h7FFF;
	localparam logic [15:0] IAP_BASE       = 16'h7A00;
	localparam logic [15:0] IAP_END        = 16'h7DFF;
	localparam logic [15:0] HI_PAGE_BASE   = 16'h7C00;
	localparam logic [15:0] PROG_LAST      = 16'h7DFE;
	localparam logic [15:0] ERASE_TRIG_LO  = 16'h7B2D;
	localparam logic [15:0] ERASE_TRIG_HI  = 16'h7D69;
	localparam int          PAGE_BYTES     = 512;
	localparam int          AREA_BYTES     = 2 * PAGE_BYTES;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          PROG_TIME_NS   = 20000;
	localparam int          ERASE_TIME_US  = 2000;
	localparam int          TO1_TIME_US    = 800;
	localparam int          TO2_TIME_US    = 3200;
	localparam int          TO3_TIME_US    = 6400;
	localparam int          PROG_CYCLES    = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ERASE_CYCLES   = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TO1_CYCLES     = (TO1_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int          TO2_CYCLES     = (TO2_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int          TO3_CYCLES     = (TO3_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam logic [1:0]  TO_SEL_OFF     = 2'h0;
	localparam logic [1:0]  TO_SEL_1       = 2'h1;
	localparam logic [1:0]  TO_SEL_2       = 2'h2;
	localparam int          TIMER_W        = 17;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROG,
		ST_ERASE
	} op_state_t;
endpackage

//--- src/pin_sync3.sv
`timescale 1ns/100ps
module pin_sync3 (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// change accepted once second and third stage agree
	always_comb begin
		next_s = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.level = s.s3;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign level = s.level;
endmodule

//--- src/op_timer.sv
`timescale 1ns/100ps
module op_timer #(
	parameter int W = 17
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         start,
	input  wire logic         advance,
	input  wire logic         cancel,
	input  wire logic [W-1:0] limit,
	output logic              expired
);
	typedef struct packed {
		logic         active;
		logic [W-1:0] remain;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	assign expired = s.active && advance && !cancel && (s.remain == W'(1));

	always_comb begin
		next_s = s;
		if (start) begin
			next_s.active = 1'b1;
			next_s.remain = limit;
		end else if (cancel || expired) begin
			next_s.active = 1'b0;
		end else if (s.active && advance) begin
			next_s.remain = s.remain - W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule

//--- src/flash_iap_ctrl.sv
`timescale 1ns/100ps
module flash_iap_ctrl #(
	parameter int ERASE_CYCLES = flash_iap_pkg::ERASE_CYCLES,
	parameter int TO1_CYCLES   = flash_iap_pkg::TO1_CYCLES,
	parameter int TO2_CYCLES   = flash_iap_pkg::TO2_CYCLES,
	parameter int TO3_CYCLES   = flash_iap_pkg::TO3_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic [7:0]  cfg_byte_in,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        movx_wr,
	input  wire logic [15:0] data_pointer,
	input  wire logic [7:0]  acc,
	input  wire logic        movc_rd,
	input  wire logic [15:0] movc_addr,
	input  wire logic [1:0]  program_timeout_select,
	input  wire logic        program_fault_pin,
	output logic [7:0]       sfr_rdata,
	output logic [7:0]       movc_rdata,
	output logic             movc_hit,
	output logic             cpu_wait,
	output logic [7:0]       configuration_word,
	output logic             program_unlock_flag,
	output logic             write_enable_active,
	output logic             program_timeout_flag
);
	localparam int TW = flash_iap_pkg::TIMER_W;
	localparam int NB = flash_iap_pkg::AREA_BYTES;
	localparam int PB = flash_iap_pkg::PAGE_BYTES;

	typedef struct packed {
		flash_iap_pkg::op_state_t state;
		logic [7:0]               key;
		logic [7:0]               code;
		logic                     cfg_loaded;
		logic [7:0]               cfg;
		logic [9:0]               target;
		logic [7:0]               data;
		logic                     erase_hi;
		logic                     to_flag;
		logic                     unlock;
		logic                     we_active;
		logic                     wait_cpu;
		logic [7:0]               rdata;
		logic [7:0]               mdata;
		logic                     mhit;
		logic [NB-1:0][7:0]       mem;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;

	// =====================================================
	// decode of the store and the arming codes
	// =====================================================
	logic        fault;
	logic        op_done;
	logic        to_expired;
	logic        key_ok;
	logic        armed;
	logic        in_lo;
	logic        in_hi;
	logic        accept_prog;
	logic        accept_erase;
	logic        start_op;
	logic        busy;
	logic [15:0] dp_off;
	logic [15:0] rd_off;
	logic [TW-1:0] op_limit;
	logic [TW-1:0] to_limit;

	assign key_ok = (s.key == flash_iap_pkg::KEY_UNLOCK);
	assign armed  = key_ok && (s.code == flash_iap_pkg::CODE_PROG_LO || s.code == flash_iap_pkg::CODE_PROG_HI
		|| s.code == flash_iap_pkg::CODE_ERASE_LO || s.code == flash_iap_pkg::CODE_ERASE_HI);
	assign in_lo  = (data_pointer >= flash_iap_pkg::IAP_BASE) && (data_pointer < flash_iap_pkg::HI_PAGE_BASE);
	assign in_hi  = (data_pointer >= flash_iap_pkg::HI_PAGE_BASE) && (data_pointer <= flash_iap_pkg::PROG_LAST);
	assign dp_off = data_pointer - flash_iap_pkg::IAP_BASE;
	assign rd_off = movc_addr - flash_iap_pkg::IAP_BASE;
	assign busy   = (s.state != flash_iap_pkg::ST_IDLE);

	// only the two pages, only with key and matching code
	assign accept_prog = movx_wr && !busy && key_ok
		&& ((s.code == flash_iap_pkg::CODE_PROG_LO && in_lo)
		|| (s.code == flash_iap_pkg::CODE_PROG_HI && in_hi));
	assign accept_erase = movx_wr && !busy && key_ok
		&& ((s.code == flash_iap_pkg::CODE_ERASE_LO && data_pointer == flash_iap_pkg::ERASE_TRIG_LO)
		|| (s.code == flash_iap_pkg::CODE_ERASE_HI && data_pointer == flash_iap_pkg::ERASE_TRIG_HI));
	assign start_op = ce && (accept_prog || accept_erase);

	assign op_limit = accept_erase ? TW'(ERASE_CYCLES) : TW'(flash_iap_pkg::PROG_CYCLES);

	always_comb begin
		unique case (program_timeout_select)
			flash_iap_pkg::TO_SEL_OFF: to_limit = TW'(1);
			flash_iap_pkg::TO_SEL_1:   to_limit = TW'(TO1_CYCLES);
			flash_iap_pkg::TO_SEL_2:   to_limit = TW'(TO2_CYCLES);
			default:                   to_limit = TW'(TO3_CYCLES);
		endcase
	end

	// =====================================================
	// flash cell fault pin and the two timers
	// =====================================================
	pin_sync3 u_fault_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.pin     (program_fault_pin),
		.level   (fault)
	);

	// a failing cell never finishes, so the operation timer stalls
	op_timer #(.W(TW)) u_op_timer (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.start   (start_op),
		.advance (!fault),
		.cancel  (to_expired),
		.limit   (op_limit),
		.expired (op_done)
	);

	op_timer #(.W(TW)) u_to_timer (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.start   (start_op && program_timeout_select != flash_iap_pkg::TO_SEL_OFF),
		.advance (1'b1),
		.cancel  (op_done),
		.limit   (to_limit),
		.expired (to_expired)
	);

	// =====================================================
	// next state
	// =====================================================
	always_comb begin
		next_s = s;
		// strap-like capture of the configuration byte after reset release
		if (!s.cfg_loaded) begin
			next_s.cfg        = cfg_byte_in;
			next_s.cfg_loaded = 1'b1;
		end
		if (sfr_wr && sfr_addr == flash_iap_pkg::KEY_SFR_ADDR) begin
			next_s.key = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == flash_iap_pkg::CODE_SFR_ADDR) begin
			next_s.code = sfr_wdata;
		end
		// set wins over the clear while the code register holds CODE_OFF
		if (busy && to_expired) begin
			next_s.to_flag = 1'b1;
		end else if (next_s.code == flash_iap_pkg::CODE_OFF) begin
			next_s.to_flag = 1'b0;
		end

		unique case (s.state)
			flash_iap_pkg::ST_IDLE: begin
				// stores that are not armed fall through untouched
				if (accept_prog) begin
					next_s.state  = flash_iap_pkg::ST_PROG;
					next_s.target = dp_off[9:0];
					next_s.data   = acc;
				end else if (accept_erase) begin
					next_s.state    = flash_iap_pkg::ST_ERASE;
					next_s.erase_hi = (s.code == flash_iap_pkg::CODE_ERASE_HI);
				end
			end
			flash_iap_pkg::ST_PROG: begin
				if (op_done) begin
					next_s.mem[s.target] = s.mem[s.target] & s.data;
					next_s.state         = flash_iap_pkg::ST_IDLE;
				end else if (to_expired) begin
					next_s.state = flash_iap_pkg::ST_IDLE;
				end
			end
			flash_iap_pkg::ST_ERASE: begin
				if (op_done) begin
					for (int i = 0; i < PB; i++) begin
						next_s.mem[{s.erase_hi, 9'(i)}] = flash_iap_pkg::ERASED_BYTE;
					end
					next_s.state = flash_iap_pkg::ST_IDLE;
				end else if (to_expired) begin
					next_s.state = flash_iap_pkg::ST_IDLE;
				end
			end
		endcase

		// cpu stalls only for the operation; timers elsewhere keep running
		next_s.wait_cpu  = (next_s.state != flash_iap_pkg::ST_IDLE);
		next_s.unlock    = (next_s.key == flash_iap_pkg::KEY_UNLOCK);
		next_s.we_active = (next_s.key == flash_iap_pkg::KEY_UNLOCK)
			&& (next_s.code == flash_iap_pkg::CODE_PROG_LO || next_s.code == flash_iap_pkg::CODE_PROG_HI
			|| next_s.code == flash_iap_pkg::CODE_ERASE_LO || next_s.code == flash_iap_pkg::CODE_ERASE_HI);

		if (sfr_rd) begin
			if (sfr_addr == flash_iap_pkg::KEY_SFR_ADDR) begin
				next_s.rdata = {7'h00, key_ok};
			end else if (sfr_addr == flash_iap_pkg::CODE_SFR_ADDR) begin
				next_s.rdata = {armed, s.to_flag, 6'h00};
			end else begin
				next_s.rdata = flash_iap_pkg::RESET_BYTE;
			end
		end

		// code reads of the area answer one cycle later
		next_s.mhit = movc_rd && (movc_addr >= flash_iap_pkg::IAP_BASE) && (movc_addr <= flash_iap_pkg::IAP_END);
		if (next_s.mhit) begin
			next_s.mdata = s.mem[rd_off[9:0]];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign sfr_rdata            = s.rdata;
	assign movc_rdata           = s.mdata;
	assign movc_hit             = s.mhit;
	assign cpu_wait             = s.wait_cpu;
	assign configuration_word   = s.cfg;
	assign program_unlock_flag  = s.unlock;
	assign write_enable_active  = s.we_active;
	assign program_timeout_flag = s.to_flag;

	// =====================================================
	// checks
	// =====================================================
	logic [7:0] old_byte;
	logic [7:0] merged_byte;
	logic       prog_commit;
	logic       erase_commit;

	assign old_byte     = s.mem[s.target];
	assign merged_byte  = s.mem[s.target] & s.data;
	assign prog_commit  = ce && s.state == flash_iap_pkg::ST_PROG && op_done;
	assign erase_commit = ce && s.state == flash_iap_pkg::ST_ERASE && op_done;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	prog_stalls_cpu_a: assert property (ce && accept_prog |=> cpu_wait && s.state == flash_iap_pkg::ST_PROG)
		else $error("byte program did not stall the cpu");
	reject_no_wait_a: assert property (ce && movx_wr && !busy && !(accept_prog || accept_erase) |=> !cpu_wait)
		else $error("unarmed store stalled the cpu");
	no_key_reject_a: assert property (ce && movx_wr && !key_ok && !busy |=> s.state == flash_iap_pkg::ST_IDLE)
		else $error("store without key started an operation");
	unlock_read_a: assert property (ce && sfr_wr && sfr_addr == flash_iap_pkg::KEY_SFR_ADDR
		&& sfr_wdata == flash_iap_pkg::KEY_UNLOCK ##1 ce && sfr_rd && sfr_addr == flash_iap_pkg::KEY_SFR_ADDR
		|=> sfr_rdata[0])
		else $error("unlock bit not reported");
	prog_and_only_a: assert property (prog_commit |=> s.mem[$past(s.target)] == $past(merged_byte))
		else $error("program result is not the and of old and new");
	erase_ones_a: assert property (erase_commit && !s.erase_hi |=> s.mem[0] == flash_iap_pkg::ERASED_BYTE
		&& s.mem[PB-1] == flash_iap_pkg::ERASED_BYTE)
		else $error("lower page not all ones after erase");
	erase_lo_start_a: assert property (ce && !busy && movx_wr && key_ok
		&& s.code == flash_iap_pkg::CODE_ERASE_LO && data_pointer == flash_iap_pkg::ERASE_TRIG_LO
		|=> s.state == flash_iap_pkg::ST_ERASE && !s.erase_hi)
		else $error("lower page erase not started");
	timeout_release_a: assert property (ce && busy && to_expired |=> program_timeout_flag && !cpu_wait)
		else $error("time-out did not release the cpu");
	prog_length_a: assert property (ce && accept_prog && program_timeout_select == flash_iap_pkg::TO_SEL_OFF
		##1 (ce && !fault)[*8] |-> cpu_wait)
		else $error("byte program ended too early");

	prog_done_c: cover property (prog_commit);
	erase_done_c: cover property (erase_commit);
	timeout_c: cover property (ce && busy && to_expired);
	movc_read_c: cover property (ce && movc_rd ##1 movc_hit);
endmodule

//--- verif/cpu_core_model.sv
`timescale 1ns/100ps
module cpu_core_model (
	input  wire logic        ref_clk,
	input  wire logic [7:0]  sfr_rdata,
	input  wire logic [7:0]  movc_rdata,
	input  wire logic        movc_hit,
	input  wire logic        cpu_wait,
	output logic             sfr_wr,
	output logic             sfr_rd,
	output logic [7:0]       sfr_addr,
	output logic [7:0]       sfr_wdata,
	output logic             movx_wr,
	output logic [15:0]      data_pointer,
	output logic [7:0]       acc,
	output logic             movc_rd,
	output logic [15:0]      movc_addr
);
	// ==========================================
	// idle bus
	initial begin
		{sfr_wr, sfr_rd, movx_wr, movc_rd} = 4'h0;
		{sfr_addr, sfr_wdata, acc} = 24'h0;
		{data_pointer, movc_addr} = 32'h0;
	end

	// ==========================================
	// bus cycles, all launched just after an edge
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	// a stalled core issues nothing
	task automatic gate();
		while (cpu_wait === 1'b1) step();
	endtask

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		gate();
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		step();
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		gate();
		sfr_rd = 1'b1;
		sfr_addr = a;
		step();
		d = sfr_rdata;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
	endtask

	task automatic store(input logic [15:0] dp, input logic [7:0] a);
		gate();
		movx_wr = 1'b1;
		data_pointer = dp;
		acc = a;
		step();
		movx_wr = 1'b0;
		data_pointer = ~dp;
		acc = ~a;
	endtask

	task automatic code_read(input logic [15:0] a, output logic [7:0] d, output logic h);
		gate();
		movc_rd = 1'b1;
		movc_addr = a;
		step();
		d = movc_rdata;
		h = movc_hit;
		movc_rd = 1'b0;
		movc_addr = ~a;
	endtask

	task automatic arm(input logic [7:0] code);
		sfr_write(8'h97, 8'h65);
		sfr_write(8'hC9, code);
	endtask

	task automatic disarm();
		sfr_write(8'h97, 8'h00);
		sfr_write(8'hC9, 8'h00);
	endtask
endmodule

//--- verif/flash_iap_write_erase_control_tb.sv
`timescale 1ns/100ps
`define chk(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end
module flash_iap_write_erase_control_tb;
	localparam int         ERASE_LEN = 300;
	localparam int         TO_LEN [0:2] = '{400, 500, 600};
	localparam logic [7:0] CFG_VALUE = 8'hA5;

	// ==========================================
	// signals
	logic        ref_clk = 1'b0;
	logic        rst_b;
	logic        ce;
	logic [7:0]  cfg_byte_in;
	logic [1:0]  program_timeout_select;
	logic        program_fault_pin;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_addr;
	logic [7:0]  sfr_wdata;
	logic        movx_wr;
	logic [15:0] data_pointer;
	logic [7:0]  acc;
	logic        movc_rd;
	logic [15:0] movc_addr;
	logic [7:0]  sfr_rdata;
	logic [7:0]  movc_rdata;
	logic        movc_hit;
	logic        cpu_wait;
	logic [7:0]  configuration_word;
	logic        program_unlock_flag;
	logic        write_enable_active;
	logic        program_timeout_flag;
	int          errors = 0;
	int          num_checks = 0;

	always #50 ref_clk = ~ref_clk;

	flash_iap_ctrl #(
		.ERASE_CYCLES (ERASE_LEN),
		.TO1_CYCLES   (TO_LEN[0]),
		.TO2_CYCLES   (TO_LEN[1]),
		.TO3_CYCLES   (TO_LEN[2])
	) dut (
		.ref_clk                (ref_clk),
		.rst_b                  (rst_b),
		.ce                     (ce),
		.cfg_byte_in            (cfg_byte_in),
		.sfr_wr                 (sfr_wr),
		.sfr_rd                 (sfr_rd),
		.sfr_addr               (sfr_addr),
		.sfr_wdata              (sfr_wdata),
		.movx_wr                (movx_wr),
		.data_pointer           (data_pointer),
		.acc                    (acc),
		.movc_rd                (movc_rd),
		.movc_addr              (movc_addr),
		.program_timeout_select (program_timeout_select),
		.program_fault_pin      (program_fault_pin),
		.sfr_rdata              (sfr_rdata),
		.movc_rdata             (movc_rdata),
		.movc_hit               (movc_hit),
		.cpu_wait               (cpu_wait),
		.configuration_word     (configuration_word),
		.program_unlock_flag    (program_unlock_flag),
		.write_enable_active    (write_enable_active),
		.program_timeout_flag   (program_timeout_flag)
	);

	cpu_core_model cpu (
		.ref_clk      (ref_clk),
		.sfr_rdata    (sfr_rdata),
		.movc_rdata   (movc_rdata),
		.movc_hit     (movc_hit),
		.cpu_wait     (cpu_wait),
		.sfr_wr       (sfr_wr),
		.sfr_rd       (sfr_rd),
		.sfr_addr     (sfr_addr),
		.sfr_wdata    (sfr_wdata),
		.movx_wr      (movx_wr),
		.data_pointer (data_pointer),
		.acc          (acc),
		.movc_rd      (movc_rd),
		.movc_addr    (movc_addr)
	);

	// ==========================================
	// shared steps
	task automatic store_check(input logic [15:0] dp, input logic [7:0] a, input int len);
		int n;
		n = 0;
		cpu.store(dp, a);
		while (cpu_wait === 1'b1 && n < 2000) begin
			cpu.step();
			n++;
		end
		`chk(n, len)
	endtask

	task automatic read_check(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       h;
		cpu.code_read(a, d, h);
		`chk(h, 1'b1)
		`chk(d, e)
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		`chk(configuration_word, CFG_VALUE)
		`chk({cpu_wait, program_unlock_flag, program_timeout_flag}, 3'h0)
		$display("test reset done");
	endtask

	task automatic t_keys();
		logic [7:0] d;
		logic [7:0] codes [4] = '{8'h4A, 8'h4C, 8'hBA, 8'hBC};
		cpu.sfr_write(8'h97, 8'h65);
		cpu.sfr_read(8'h97, d);
		`chk(d, 8'h01)
		foreach (codes[i]) begin
			cpu.sfr_write(8'hC9, codes[i]);
			cpu.sfr_read(8'hC9, d);
			`chk(d, 8'h80)
			`chk(write_enable_active, 1'b1)
		end
		cpu.sfr_write(8'hC9, 8'h4B);
		cpu.sfr_read(8'hC9, d);
		`chk(d, 8'h00)
		cpu.sfr_write(8'h97, 8'h00);
		cpu.sfr_write(8'hC9, 8'hBA);
		cpu.sfr_read(8'hC9, d);
		`chk(d, 8'h00)
		`chk(program_unlock_flag, 1'b0)
		cpu.disarm();
		$display("test keys done");
	endtask

	task automatic t_erase();
		cpu.arm(8'hBA);
		store_check(16'h7B2C, 8'h00, 0);
		store_check(16'h7D69, 8'h00, 0);
		store_check(16'h7B2D, 8'h33, ERASE_LEN);
		cpu.disarm();
		read_check(16'h7A00, 8'hFF);
		read_check(16'h7BFF, 8'hFF);
		read_check(16'h7C00, 8'h00);
		cpu.arm(8'hBC);
		store_check(16'h7D69, 8'hC7, ERASE_LEN);
		cpu.disarm();
		read_check(16'h7C00, 8'hFF);
		read_check(16'h7DFF, 8'hFF);
		$display("test erase done");
	endtask

	// pages were erased first, each byte is programmed once
	task automatic t_program();
		logic [7:0] d;
		logic       h;
		cpu.arm(8'h4A);
		store_check(16'h7C10, 8'h00, 0);
		store_check(16'h79FF, 8'h00, 0);
		store_check(16'h7A00, 8'h5A, 200);
		cpu.disarm();
		read_check(16'h7A00, 8'h5A);
		cpu.arm(8'h4C);
		store_check(16'h7DFF, 8'h00, 0);
		store_check(16'h7E00, 8'h00, 0);
		store_check(16'h7DFE, 8'h3C, 200);
		cpu.disarm();
		read_check(16'h7DFE, 8'h3C);
		read_check(16'h7DFF, 8'hFF);
		cpu.sfr_write(8'hC9, 8'h4A);
		store_check(16'h7A01, 8'h00, 0);
		cpu.disarm();
		read_check(16'h7A01, 8'hFF);
		cpu.code_read(16'h79FF, d, h);
		`chk(h, 1'b0)
		$display("test program done");
	endtask

	task automatic t_timeout();
		logic [7:0] d;
		program_fault_pin = 1'b1;
		for (int s = 1; s < 4; s++) begin
			program_timeout_select = 2'(s);
			cpu.arm(8'h4A);
			store_check(16'h7A20, 8'h00, TO_LEN[s-1]);
			cpu.sfr_read(8'hC9, d);
			`chk(d, 8'hC0)
			`chk(program_timeout_flag, 1'b1)
			cpu.disarm();
			cpu.step();
			`chk(program_timeout_flag, 1'b0)
			read_check(16'h7A20, 8'hFF);
		end
		program_fault_pin = 1'b0;
		$display("test timeout done");
	endtask

	// clock enable low freezes the key register
	task automatic t_freeze();
		logic [7:0] d;
		ce = 1'b0;
		cpu.sfr_write(8'h97, 8'h65);
		`chk(program_unlock_flag, 1'b0)
		cpu.step();
		ce = 1'b1;
		cpu.sfr_read(8'h97, d);
		`chk(d, 8'h00)
		$display("test freeze done");
	endtask

	// ==========================================
	// run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		cfg_byte_in = CFG_VALUE;
		program_timeout_select = 2'h0;
		program_fault_pin = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		cpu.step();
		t_reset();
		t_keys();
		t_erase();
		t_program();
		t_timeout();
		t_freeze();
		end_of_test();
	end

	initial begin
		repeat (10000) @(posedge ref_clk);
		errors++;
		end_of_test();
	end
endmodule
